// [design/modbus_io_pkg.sv]
package modbus_io_pkg;

	// ----------------------------------------------------------------
	// network ports
	// ----------------------------------------------------------------
	localparam logic [15:0] IO_PORT  = 16'h1196;
	localparam logic [15:0] FWD_PORT = 16'h01F6;

	// ----------------------------------------------------------------
	// register numbers (first word of each range)
	// ----------------------------------------------------------------
	localparam logic [15:0] REG_STATION     = 16'h0000;
	localparam logic [15:0] REG_STATUS      = 16'h0001;
	localparam logic [15:0] REG_PACKED_IN   = 16'h0002;
	localparam logic [15:0] REG_AIN_ALT     = 16'h0096;
	localparam logic [15:0] REG_PACKED_OUT  = 16'h012C;
	localparam logic [15:0] REG_AOUT_PACKED = 16'h0190;
	localparam logic [15:0] REG_AIN         = 16'h01AE;
	localparam logic [15:0] REG_DIN         = 16'h01C2;
	localparam logic [15:0] REG_CNT_ALT     = 16'h01F4;
	localparam logic [15:0] REG_CNT         = 16'h0258;
	localparam logic [15:0] REG_DOUT        = 16'h02EE;
	localparam logic [15:0] REG_AOUT        = 16'h0320;

	// ----------------------------------------------------------------
	// sizes and packed layouts
	// ----------------------------------------------------------------
	localparam int          N_DIN        = 16;
	localparam int          N_AIN        = 4;
	localparam int          N_DOUT       = 8;
	localparam int          N_AOUT       = 4;
	localparam int          ADC_BITS     = 12;
	localparam logic [15:0] PK_AIN_POS   = 16'h0001;
	localparam logic [15:0] PK_CNT_POS   = 16'h0005;
	localparam logic [15:0] PK_IN_WORDS  = 16'h0015;
	localparam logic [15:0] PK_AOUT_POS  = 16'h0001;
	localparam logic [15:0] PK_OUT_WORDS = 16'h0005;
	localparam logic [15:0] AIN_WORDS    = 16'h0004;
	localparam logic [15:0] AOUT_WORDS   = 16'h0004;
	localparam logic [15:0] CNT_WORDS    = 16'h0010;
	localparam logic [15:0] ONE_WORD     = 16'h0001;

	// ----------------------------------------------------------------
	// status byte fields and reset values
	// ----------------------------------------------------------------
	localparam int          ST_RESTART   = 7;
	localparam int          ST_IO_ERR    = 6;
	localparam int          ST_TIME      = 4;
	localparam int          ST_OK        = 3;
	localparam int          ST_RADIO     = 1;
	localparam logic [7:0]  STRENGTH_UNREG = 8'hFF;
	localparam logic [7:0]  DOUT_RESET   = 8'h00;
	localparam logic [11:0] AOUT_RESET   = 12'h000;
	localparam logic [15:0] CNT_RESET    = 16'h0000;
	localparam logic [15:0] MODE_DEFAULT = 16'hFF00;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ        = 50_000_000;
	localparam int TIMER_RES_S   = 1;
	localparam int SECOND_CYCLES = TIMER_RES_S * CLK_HZ;

endpackage : modbus_io_pkg

// [design/modbus_io_register_map.sv]
`timescale 1ns/1ns
// Function
// - I/O registers answer on network port 4502; the master addresses that port.
// - with port-502 forwarding set, frames to port 502 go to local Ethernet.
// - every register is presented as one 16-bit word.
// - register 0 returns the own station address.
// - register 1 high byte holds signal strength as magnitude of negative dBm.
// - signal strength byte reads 255 while not registered to the network.
// - status bit 7 set on restart, cleared by writing one to it.
// - status bit 6 set on any input/output error.
// - writing one to bit 6 clears it only once the error has gone.
// - status bit 4 high while system time is valid.
// - status bit 3 high while the device operates correctly.
// - status bit 1 high while the radio section is in error.
// - reads from register 2 return packed digital, analog and counter inputs.
// - analog inputs are 12-bit, right-aligned, top four bits zero.
// - digital input line zero of first port is the LSB, ascending.
// - one 16-bit counter per input, first port line zero first.
// - first-port counters count events, second-port counters count active seconds.
// - digital output line zero maps to the LSB of writes.
// - range from 300 presents packed output data including digital outputs.
// - analog outputs are 12-bit values from register 400.
// - analog output range from 800 starts with fourth-port channel zero.
// - counters register input pulses up to 10 per second.
module modbus_io_register_map #(
	parameter int          SECOND_CYCLES = modbus_io_pkg::SECOND_CYCLES,
	parameter logic [15:0] COUNTER_MODE  = modbus_io_pkg::MODE_DEFAULT
) (
	input  wire logic                    i_clk,
	input  wire logic                    i_rst_b,
	input  wire logic                    i_req_valid,
	input  wire logic [15:0]             i_req_port,
	input  wire logic                    i_req_write,
	input  wire logic [15:0]             i_req_addr,
	input  wire logic [15:0]             i_req_wdata,
	input  wire logic                    i_forward_502,
	output logic                         o_rsp_valid,
	output logic                         o_rsp_error,
	output logic [15:0]                  o_rsp_rdata,
	output logic                         o_forward,
	input  wire logic [7:0]              i_station_address,
	input  wire logic [7:0]              i_received_signal_strength,
	input  wire logic                    i_registered,
	input  wire logic                    i_io_fault,
	input  wire logic                    i_time_valid,
	input  wire logic                    i_operating_ok,
	input  wire logic                    i_radio_error,
	input  wire logic [15:0]             i_digital_in,
	input  wire logic [3:0][11:0]        i_analog_in,
	output logic [7:0]                   o_digital_out,
	output logic [3:0][11:0]             o_analog_out
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic in_range(input logic [15:0] a, input logic [15:0] base, input logic [15:0] n);
		logic [15:0] d;
		d = a - base;
		in_range = (a >= base) && (d < n);
	endfunction : in_range

	function automatic logic [15:0] rel(input logic [15:0] a, input logic [15:0] base);
		rel = a - base;
	endfunction : rel

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [15:0] din_meta;
	logic [15:0] din_sync;
	logic [15:0] din_prev;
	logic [15:0] cnt [0:15];
	logic [25:0] sec_cnt;
	logic        sec_tick;
	logic        restart;
	logic        io_err;
	logic [15:0] pk_in  [0:20];
	logic [15:0] pk_out [0:4];

	// ----------------------------------------------------------------
	// request decode
	// ----------------------------------------------------------------
	wire for_io  = i_req_valid && (i_req_port == modbus_io_pkg::IO_PORT);
	wire for_fwd = i_req_valid && (i_req_port == modbus_io_pkg::FWD_PORT) && i_forward_502;
	wire wr      = for_io && i_req_write;
	wire rd      = for_io && !i_req_write;

	wire hit_station = i_req_addr == modbus_io_pkg::REG_STATION;
	wire hit_status  = i_req_addr == modbus_io_pkg::REG_STATUS;
	wire hit_pk_in   = in_range(i_req_addr, modbus_io_pkg::REG_PACKED_IN, modbus_io_pkg::PK_IN_WORDS);
	wire hit_ain_alt = in_range(i_req_addr, modbus_io_pkg::REG_AIN_ALT, modbus_io_pkg::AIN_WORDS);
	wire hit_pk_out  = in_range(i_req_addr, modbus_io_pkg::REG_PACKED_OUT, modbus_io_pkg::PK_OUT_WORDS);
	wire hit_aout_pk = in_range(i_req_addr, modbus_io_pkg::REG_AOUT_PACKED, modbus_io_pkg::AOUT_WORDS);
	wire hit_ain     = in_range(i_req_addr, modbus_io_pkg::REG_AIN, modbus_io_pkg::AIN_WORDS);
	wire hit_din     = i_req_addr == modbus_io_pkg::REG_DIN;
	wire hit_cnt_alt = in_range(i_req_addr, modbus_io_pkg::REG_CNT_ALT, modbus_io_pkg::CNT_WORDS);
	wire hit_cnt     = in_range(i_req_addr, modbus_io_pkg::REG_CNT, modbus_io_pkg::CNT_WORDS);
	wire hit_dout    = i_req_addr == modbus_io_pkg::REG_DOUT;
	wire hit_aout    = in_range(i_req_addr, modbus_io_pkg::REG_AOUT, modbus_io_pkg::AOUT_WORDS);

	wire [15:0] off_pk_in   = rel(i_req_addr, modbus_io_pkg::REG_PACKED_IN);
	wire [15:0] off_ain_alt = rel(i_req_addr, modbus_io_pkg::REG_AIN_ALT);
	wire [15:0] off_pk_out  = rel(i_req_addr, modbus_io_pkg::REG_PACKED_OUT);
	wire [15:0] off_aout_pk = rel(i_req_addr, modbus_io_pkg::REG_AOUT_PACKED);
	wire [15:0] off_ain     = rel(i_req_addr, modbus_io_pkg::REG_AIN);
	wire [15:0] off_cnt_alt = rel(i_req_addr, modbus_io_pkg::REG_CNT_ALT);
	wire [15:0] off_cnt     = rel(i_req_addr, modbus_io_pkg::REG_CNT);
	wire [15:0] off_aout    = rel(i_req_addr, modbus_io_pkg::REG_AOUT);
	wire [15:0] off_pk_aout = off_pk_out - modbus_io_pkg::PK_AOUT_POS;

	wire hit_ro = hit_station || hit_pk_in || hit_ain_alt || hit_ain || hit_din || hit_cnt_alt || hit_cnt;
	wire hit_rw = hit_status || hit_pk_out || hit_aout_pk || hit_dout || hit_aout;
	// read-only ranges refuse writes so the master sees an exception, not silent loss
	wire req_bad = !(hit_ro || hit_rw) || (i_req_write && !hit_rw);

	// ----------------------------------------------------------------
	// status word
	// ----------------------------------------------------------------
	wire [7:0] strength_byte = i_registered ? i_received_signal_strength : modbus_io_pkg::STRENGTH_UNREG;
	wire [7:0] status_byte = {restart, io_err, 1'b0, i_time_valid, i_operating_ok, 1'b0, i_radio_error, 1'b0};
	wire       wr_status = wr && hit_status && !req_bad;
	wire       clr_restart = wr_status && i_req_wdata[modbus_io_pkg::ST_RESTART];
	wire       clr_io_err  = wr_status && i_req_wdata[modbus_io_pkg::ST_IO_ERR];

	// ----------------------------------------------------------------
	// packed views
	// ----------------------------------------------------------------
	always_comb begin
		pk_in[0] = din_sync;
		for (int i = 0; i < modbus_io_pkg::N_AIN; i++) begin
			pk_in[1 + i] = {4'h0, i_analog_in[i]};
		end
		for (int i = 0; i < modbus_io_pkg::N_DIN; i++) begin
			pk_in[5 + i] = cnt[i];
		end
		pk_out[0] = {8'h00, o_digital_out};
		for (int i = 0; i < modbus_io_pkg::N_AOUT; i++) begin
			pk_out[1 + i] = {4'h0, o_analog_out[i]};
		end
	end

	wire [15:0] rd_word =
		hit_station ? {8'h00, i_station_address} :
		hit_status  ? {strength_byte, status_byte} :
		hit_pk_in   ? pk_in[off_pk_in[4:0]] :
		hit_ain_alt ? pk_in[3'(off_ain_alt[1:0]) + 3'(modbus_io_pkg::PK_AIN_POS)] :
		hit_ain     ? pk_in[3'(off_ain[1:0]) + 3'(modbus_io_pkg::PK_AIN_POS)] :
		hit_din     ? din_sync :
		hit_cnt_alt ? cnt[off_cnt_alt[3:0]] :
		hit_cnt     ? cnt[off_cnt[3:0]] :
		hit_pk_out  ? pk_out[off_pk_out[2:0]] :
		hit_aout_pk ? pk_out[3'(off_aout_pk[1:0]) + 3'(modbus_io_pkg::PK_AOUT_POS)] :
		hit_dout    ? pk_out[0] :
		hit_aout    ? pk_out[3'(off_aout[1:0]) + 3'(modbus_io_pkg::PK_AOUT_POS)] :
		16'h0000;

	// ----------------------------------------------------------------
	// output writes
	// ----------------------------------------------------------------
	wire       wr_ok   = wr && !req_bad;
	wire       wr_dout = wr_ok && (hit_dout || (hit_pk_out && off_pk_out == 16'h0000));
	wire       wr_aout = wr_ok && (hit_aout || hit_aout_pk || (hit_pk_out && off_pk_out != 16'h0000));
	wire [1:0] aout_ch = hit_aout ? off_aout[1:0] : hit_aout_pk ? off_aout_pk[1:0] : off_pk_aout[1:0];

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_digital_out <= modbus_io_pkg::DOUT_RESET;
			for (int i = 0; i < modbus_io_pkg::N_AOUT; i++) begin
				o_analog_out[i] <= modbus_io_pkg::AOUT_RESET;
			end
		end else begin
			if (wr_dout) begin
				o_digital_out <= i_req_wdata[7:0];
			end
			if (wr_aout) begin
				o_analog_out[aout_ch] <= i_req_wdata[11:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// status flags
	// ----------------------------------------------------------------
	// a fault present in the clearing cycle keeps the flag set
	wire next_io_err = i_io_fault || (io_err && !clr_io_err);

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			restart <= 1'b1;
			io_err  <= 1'b0;
		end else begin
			restart <= restart && !clr_restart;
			io_err  <= next_io_err;
		end
	end

	// ----------------------------------------------------------------
	// input sync, counters and timers
	// ----------------------------------------------------------------
	// pulse edges come from the synchronised level, so any rate far below the clock is caught
	wire [15:0] din_rise = din_sync & ~din_prev;
	wire        sec_wrap = sec_cnt == 26'(SECOND_CYCLES - 1);

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			din_meta <= 16'h0000;
			din_sync <= 16'h0000;
			din_prev <= 16'h0000;
			sec_cnt  <= 26'h0000000;
			sec_tick <= 1'b0;
		end else begin
			din_meta <= i_digital_in;
			din_sync <= din_meta;
			din_prev <= din_sync;
			sec_cnt  <= sec_wrap ? 26'h0000000 : sec_cnt + 26'h0000001;
			sec_tick <= sec_wrap;
		end
	end

	always_ff @(posedge i_clk) begin
		for (int i = 0; i < modbus_io_pkg::N_DIN; i++) begin
			if (!i_rst_b) begin
				cnt[i] <= modbus_io_pkg::CNT_RESET;
			end else if (COUNTER_MODE[i] ? (sec_tick && din_sync[i]) : din_rise[i]) begin
				cnt[i] <= cnt[i] + 16'h0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// response
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_rsp_valid <= 1'b0;
			o_rsp_error <= 1'b0;
			o_rsp_rdata <= 16'h0000;
			o_forward   <= 1'b0;
		end else begin
			o_rsp_valid <= for_io;
			o_rsp_error <= for_io && req_bad;
			o_rsp_rdata <= (for_io && !req_bad) ? (i_req_write ? i_req_wdata : rd_word) : 16'h0000;
			o_forward   <= for_fwd;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	io_port_a: assert property (for_io |=> o_rsp_valid) else $error("io port request not answered");
	other_port_a: assert property (!for_io |=> !o_rsp_valid) else $error("answer without io port request");
	forward_a: assert property (for_fwd |=> o_forward && !o_rsp_valid) else $error("forward frame mishandled");
	station_a: assert property (rd && hit_station |=> o_rsp_rdata == {8'h00, $past(i_station_address)})
		else $error("station address wrong");
	strength_a: assert property (rd && hit_status && i_registered
		|=> o_rsp_rdata[15:8] == $past(i_received_signal_strength)) else $error("signal strength wrong");
	strength_unreg_a: assert property (rd && hit_status && !i_registered |=> o_rsp_rdata[15:8] == 8'hFF)
		else $error("unregistered strength not 255");
	restart_set_a: assert property ($rose(i_rst_b) |-> restart) else $error("restart flag not set");
	restart_clr_a: assert property (clr_restart |=> !restart ##1 !restart) else $error("restart flag not cleared");
	io_err_hold_a: assert property (i_io_fault |=> io_err) else $error("io error flag not held");
	io_err_clr_a: assert property (clr_io_err && !i_io_fault |=> !io_err) else $error("io error flag not cleared");
	live_bits_a: assert property (rd && hit_status |=> o_rsp_rdata[4:3] == {$past(i_time_valid), $past(i_operating_ok)}
		&& o_rsp_rdata[1] == $past(i_radio_error)) else $error("live status bits wrong");
	reserved_a: assert property (rd && hit_status |=> o_rsp_rdata[5] == 1'b0 && o_rsp_rdata[2] == 1'b0
		&& o_rsp_rdata[0] == 1'b0) else $error("reserved status bits not zero");
	ain_top_a: assert property (rd && (hit_ain || hit_ain_alt) |=> o_rsp_rdata[15:12] == 4'h0)
		else $error("analog input top bits not zero");
	din_lsb_a: assert property (rd && hit_din |=> o_rsp_rdata[0] == $past(din_sync[0]))
		else $error("digital input order wrong");
	event_cnt_a: assert property (din_rise[0] |=> cnt[0] == $past(cnt[0]) + 16'h0001)
		else $error("event counter missed a pulse");
	dout_a: assert property (wr_ok && hit_dout |=> o_digital_out == $past(i_req_wdata[7:0]))
		else $error("digital output write lost");
	aout_ch0_a: assert property (wr_ok && i_req_addr == modbus_io_pkg::REG_AOUT
		|=> o_analog_out[0] == $past(i_req_wdata[11:0])) else $error("fourth port channel zero wrong");

	// ----------------------------------------------------------------
	// response and forwarding checks
	// ----------------------------------------------------------------
	err_rsp_a: assert property (for_io && req_bad |=> o_rsp_error)
		else $error("refused request not flagged");

	err_data_a: assert property (for_io && req_bad |=> o_rsp_rdata == 16'h0000)
		else $error("refused request returned data");

	wr_echo_a: assert property (wr_ok |=> o_rsp_rdata == $past(i_req_wdata))
		else $error("write echo wrong");

	no_fwd_a: assert property (!for_fwd |=> !o_forward)
		else $error("forward pulse without frame");

	fwd_off_a: assert property (i_req_valid && i_req_port == modbus_io_pkg::FWD_PORT && !i_forward_502
		|=> !o_forward && !o_rsp_valid)
		else $error("frame forwarded with entry removed");

	// ----------------------------------------------------------------
	// packed input and counter order checks
	// ----------------------------------------------------------------
	pk_din_a: assert property (rd && hit_pk_in && off_pk_in == 16'h0000
		|=> o_rsp_rdata == $past(din_sync))
		else $error("packed digital inputs wrong");

	pk_ain_a: assert property (rd && hit_pk_in && off_pk_in == 16'h0001
		|=> o_rsp_rdata == {4'h0, $past(i_analog_in[0])})
		else $error("packed analog input wrong");

	pk_cnt_a: assert property (rd && hit_pk_in && off_pk_in == 16'h0005
		|=> o_rsp_rdata == $past(cnt[0]))
		else $error("packed counter wrong");

	cnt_order_a: assert property (rd && i_req_addr == modbus_io_pkg::REG_CNT
		|=> o_rsp_rdata == $past(cnt[0]))
		else $error("first counter word not line zero");

	// ----------------------------------------------------------------
	// counter and timer checks
	// ----------------------------------------------------------------
	timer_cnt_a: assert property (sec_tick && din_sync[8]
		|=> cnt[8] == $past(cnt[8]) + 16'h0001)
		else $error("timer missed a second");

	timer_idle_a: assert property (!sec_tick |=> $stable(cnt[8]))
		else $error("timer moved between seconds");

	event_idle_a: assert property (!din_rise[0] |=> $stable(cnt[0]))
		else $error("event counter moved without pulse");

	// ----------------------------------------------------------------
	// output and flag checks
	// ----------------------------------------------------------------
	pk_dout_a: assert property (rd && hit_pk_out && off_pk_out == 16'h0000
		|=> o_rsp_rdata == {8'h00, $past(o_digital_out)})
		else $error("packed digital outputs wrong");

	aout_pk_a: assert property (wr_ok && hit_aout_pk && off_aout_pk == 16'h0000
		|=> o_analog_out[0] == $past(i_req_wdata[11:0]))
		else $error("analog output write lost");

	dout_hold_a: assert property (!wr_dout |=> $stable(o_digital_out))
		else $error("digital outputs changed without write");

	restart_hold_a: assert property (!restart && !clr_restart |=> !restart)
		else $error("restart flag set without restart");

	forward_c: cover property (for_fwd ##1 o_forward);
	status_clr_c: cover property (restart ##1 clr_restart ##1 !restart);
	cnt_read_c: cover property (rd && hit_cnt && cnt[0] != 16'h0000);
	dout_c: cover property (wr_dout ##1 o_digital_out != 8'h00);
	err_c: cover property (for_io && req_bad ##1 o_rsp_error);

endmodule : modbus_io_register_map

// [verif/modbus_master_model.sv]
`timescale 1ns/1ns
module modbus_master_model (
	input  wire logic        i_clk,
	input  wire logic        i_rsp_valid,
	input  wire logic        i_rsp_error,
	input  wire logic [15:0] i_rsp_rdata,
	input  wire logic        i_forward,
	output logic             o_req_valid,
	output logic [15:0]      o_req_port,
	output logic             o_req_write,
	output logic [15:0]      o_req_addr,
	output logic [15:0]      o_req_wdata
);
	initial begin
		o_req_valid = 1'b0;
		o_req_port  = 16'h0000;
		o_req_write = 1'b0;
		o_req_addr  = 16'h0000;
		o_req_wdata = 16'h0000;
	end

	// ----------------------------------------------------------------
	// one word per request, answer sampled in the cycle after the take
	// ----------------------------------------------------------------
	task automatic xfer(input logic [15:0] port, input logic wr, input logic [15:0] addr,
		input logic [15:0] wdata, output logic vld, output logic err, output logic [15:0] rdata,
		output logic fwd);
		@(negedge i_clk);
		o_req_valid = 1'b1;
		o_req_port  = port;
		o_req_write = wr;
		o_req_addr  = addr;
		o_req_wdata = wdata;
		@(posedge i_clk);
		@(negedge i_clk);
		// released lines must not keep showing the last value
		o_req_valid = 1'b0;
		o_req_port  = ~port;
		o_req_write = ~wr;
		o_req_addr  = ~addr;
		o_req_wdata = ~wdata;
		vld   = i_rsp_valid;
		err   = i_rsp_error;
		rdata = i_rsp_rdata;
		fwd   = i_forward;
	endtask : xfer
endmodule : modbus_master_model

// [verif/tb_modbus_io_register_map.sv]
`timescale 1ns/1ns
module tb_modbus_io_register_map;
	logic             clk, rst_b, req_valid, req_write, fwd_502, rsp_valid, rsp_error, forward;
	logic [15:0]      req_port, req_addr, req_wdata, rsp_rdata, din;
	logic [7:0]       station, strength, dout;
	logic             registered, io_fault, time_valid, op_ok, radio_err;
	logic [3:0][11:0] ain, aout;
	int               n_fail, checks;
	logic             v, e, f;
	logic [15:0]      d, base;

	modbus_master_model master_i (.i_clk(clk), .i_rsp_valid(rsp_valid), .i_rsp_error(rsp_error),
		.i_rsp_rdata(rsp_rdata), .i_forward(forward), .o_req_valid(req_valid), .o_req_port(req_port),
		.o_req_write(req_write), .o_req_addr(req_addr), .o_req_wdata(req_wdata));
	modbus_io_register_map #(.SECOND_CYCLES(20)) modbus_io_register_map_i (.i_clk(clk), .i_rst_b(rst_b),
		.i_req_valid(req_valid), .i_req_port(req_port), .i_req_write(req_write), .i_req_addr(req_addr),
		.i_req_wdata(req_wdata), .i_forward_502(fwd_502), .o_rsp_valid(rsp_valid), .o_rsp_error(rsp_error),
		.o_rsp_rdata(rsp_rdata), .o_forward(forward), .i_station_address(station),
		.i_received_signal_strength(strength), .i_registered(registered), .i_io_fault(io_fault),
		.i_time_valid(time_valid), .i_operating_ok(op_ok), .i_radio_error(radio_err), .i_digital_in(din),
		.i_analog_in(ain), .o_digital_out(dout), .o_analog_out(aout));

	// ----------------------------------------------------------------
	// shared helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic rd(input logic [15:0] a, output logic [15:0] q);
		master_i.xfer(modbus_io_pkg::IO_PORT, 1'b0, a, 16'h0000, v, e, q, f);
		check({14'h0000, v, e}, 16'h0002);
	endtask : rd

	task automatic wr(input logic [15:0] a, input logic [15:0] w);
		master_i.xfer(modbus_io_pkg::IO_PORT, 1'b1, a, w, v, e, d, f);
		check({14'h0000, v, e}, 16'h0002);
		check(d, w);
	endtask : wr

	task automatic final_report;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : final_report

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_status;
		rd(16'h0000, d);
		check(d, 16'h002C);
		rd(16'h0001, d);
		check(d, 16'hFF88);
		@(negedge clk) registered = 1'b1;
		wr(16'h0001, 16'h0025);
		rd(16'h0001, d);
		check(d, 16'h5A88);
		wr(16'h0001, 16'h0080);
		rd(16'h0001, d);
		check(d, 16'h5A08);
		@(negedge clk) {time_valid, op_ok, radio_err} = 3'b101;
		rd(16'h0001, d);
		check(d, 16'h5A12);
		@(negedge clk) {time_valid, op_ok, radio_err} = 3'b010;
		rd(16'h0001, d);
		check(d, 16'h5A08);
	endtask : t_status

	task automatic t_io_error;
		@(negedge clk) io_fault = 1'b1;
		rd(16'h0001, d);
		check(d, 16'h5A48);
		wr(16'h0001, 16'h0040);
		rd(16'h0001, d);
		check(d, 16'h5A48);
		@(negedge clk) io_fault = 1'b0;
		rd(16'h0001, d);
		check(d, 16'h5A48);
		wr(16'h0001, 16'h0040);
		rd(16'h0001, d);
		check(d, 16'h5A08);
	endtask : t_io_error

	task automatic t_inputs;
		@(negedge clk) din = 16'h8001;
		repeat (4) @(negedge clk);
		rd(16'h0002, d);
		check(d, 16'h8001);
		rd(16'd450, d);
		check(d, 16'h8001);
		for (int k = 0; k < 4; k++) begin
			rd(16'd3 + k[15:0], d);
			check(d, {4'h0, ain[k]});
			rd(16'd150 + k[15:0], d);
			check(d, {4'h0, ain[k]});
			rd(16'd430 + k[15:0], d);
			check(d, {4'h0, ain[k]});
		end
		@(negedge clk) din = 16'h0000;
		repeat (4) @(negedge clk);
	endtask : t_inputs

	task automatic t_counters;
		rd(16'd600, base);
		for (int k = 0; k < 3; k++) begin
			@(negedge clk) din[0] = 1'b1;
			repeat (4) @(negedge clk);
			din[0] = 1'b0;
			repeat (4) @(negedge clk);
		end
		rd(16'd600, d);
		check(d, base + 16'h0003);
		rd(16'd7, d);
		check(d, base + 16'h0003);
		rd(16'd500, d);
		check(d, base + 16'h0003);
		@(negedge clk) din[9:8] = 2'b11;
		din[1] = 1'b1;
		repeat (60) @(negedge clk);
		din = 16'h0000;
		repeat (4) @(negedge clk);
		rd(16'd601, d);
		check(d, 16'h0001);
		rd(16'd609, d);
		check({15'h0000, d >= 16'h0002 && d <= 16'h0003}, 16'h0001);
	endtask : t_counters

	task automatic t_outputs;
		wr(16'd750, 16'h00A5);
		check({8'h00, dout}, 16'h00A5);
		rd(16'd300, d);
		check(d, 16'h00A5);
		wr(16'd400, 16'hF123);
		check({4'h0, aout[0]}, 16'h0123);
		rd(16'd301, d);
		check(d, 16'h0123);
		wr(16'd803, 16'h0456);
		check({4'h0, aout[3]}, 16'h0456);
		rd(16'd403, d);
		check(d, 16'h0456);
	endtask : t_outputs

	task automatic t_reset;
		@(negedge clk) rst_b = 1'b0;
		repeat (2) @(negedge clk);
		rst_b = 1'b1;
		check({8'h00, dout}, 16'h0000);
		check({4'h0, aout[3]}, 16'h0000);
		rd(16'h0001, d);
		check(d, 16'h5A88);
	endtask : t_reset

	task automatic t_ports;
		master_i.xfer(modbus_io_pkg::FWD_PORT, 1'b0, 16'h0000, 16'h0000, v, e, d, f);
		check({14'h0000, v, f}, 16'h0001);
		@(negedge clk) fwd_502 = 1'b0;
		master_i.xfer(modbus_io_pkg::FWD_PORT, 1'b0, 16'h0000, 16'h0000, v, e, d, f);
		check({14'h0000, v, f}, 16'h0000);
		master_i.xfer(modbus_io_pkg::IO_PORT, 1'b1, 16'h0000, 16'h0077, v, e, d, f);
		check({v, e, d[13:0]}, 16'hC000);
		rd(16'h0000, d);
		check(d, 16'h002C);
		master_i.xfer(modbus_io_pkg::IO_PORT, 1'b0, 16'd23, 16'h0000, v, e, d, f);
		check({v, e, d[13:0]}, 16'hC000);
	endtask : t_ports

	// ----------------------------------------------------------------
	// clock, reset, sequence, watchdog
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		n_fail = 0;
		checks = 0;
		rst_b = 1'b0;
		fwd_502 = 1'b1;
		station = 8'h2C;
		strength = 8'h5A;
		{registered, io_fault, time_valid, op_ok, radio_err} = 5'b00010;
		din = 16'h0000;
		ain = {12'hDDD, 12'hCCC, 12'hBBB, 12'hAAA};
		repeat (16) @(negedge clk);
		rst_b = 1'b1;
		t_status();
		t_io_error();
		t_inputs();
		t_counters();
		t_outputs();
		t_reset();
		t_ports();
		final_report();
	end

	initial begin
		#400000;
		n_fail++;
		final_report();
	end
endmodule : tb_modbus_io_register_map
